/* verification/odtc_mc_model.sv */
// memory controller model: command clock, termination pin and commands
`timescale 1ns/1ps
module odtc_mc_model (
    // bus clock
    input wire logic pclk,
    // memory-side pins
    output logic ck,
    output logic odt,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic cmd_mrs,
    output logic otf_bc4,
    output logic [2:0] mrs_sel,
    output logic [13:0] mrs_addr
);
    int ticks = 0;
    initial begin
        {ck, odt, cmd_wr, cmd_rd, cmd_mrs, otf_bc4, mrs_sel} = '0;
        mrs_addr = 14'h3FFF;
        forever #80 ck = ~ck;
    end
    always @(posedge ck) ticks++;
    // one command per tick, held from a falling ck edge to the next one
    task automatic issue(input logic [2:0] k, input logic b, input logic [2:0] s,
                         input logic [13:0] v);
        @(negedge ck);
        @(posedge pclk);
        {cmd_mrs, cmd_rd, cmd_wr} <= k;
        otf_bc4 <= b;
        mrs_sel <= s;
        mrs_addr <= v;
        @(negedge ck);
        @(posedge pclk);
        {cmd_mrs, cmd_rd, cmd_wr, otf_bc4} <= '0;
        mrs_addr <= ~v;
    endtask : issue
    task automatic pin(input logic l);
        @(negedge ck);
        @(posedge pclk);
        odt <= l;
    endtask : pin
endmodule : odtc_mc_model

/* verification/tb_top.sv */
// self-checking bench for the termination controller
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic ck, odt, cmd_wr, cmd_rd, cmd_mrs, otf_bc4, wr_window, rd_window;
    logic [2:0] mrs_sel, term_code, code_in;
    logic [13:0] mrs_addr;
    odtc_pkg::odtc_term_t term_sel;
    int n_errors = 0;
    int checked = 0;
    int t0, on_t, off_t, dt, np;
    logic [4:0] wc[9] = '{5'h00, 5'h08, 5'h10, 5'h10, 5'h04, 5'h0C, 5'h0A, 5'h02, 5'h06};
    int won[9] = '{9, 9, 9, 9, 9, 9, 8, 8, 8};
    int woff[9] = '{15, 13, 13, 15, 16, 16, 13, 15, 16};
    odtc_ctrl dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ck, .odt, .cmd_wr, .cmd_rd, .cmd_mrs, .otf_bc4, .mrs_sel, .mrs_addr,
        .term_sel, .term_code, .wr_window, .rd_window
    );
    odtc_mc_model m (
        .pclk, .ck, .odt, .cmd_wr, .cmd_rd, .cmd_mrs, .otf_bc4, .mrs_sel, .mrs_addr
    );
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) n_errors++;
    endtask : apb
    task automatic cmd(input logic [2:0] k, input logic b, input logic [2:0] s,
                       input logic [13:0] v);
        m.issue(k, b, s, v);
        t0 = m.ticks;
    endtask : cmd
    // ticks from the command to the rise and fall of a window
    task automatic span(input logic r);
        logic w;
        on_t = -1;
        off_t = -1;
        for (int n = 0; n < 400 && off_t < 0; n++) begin
            @(posedge pclk);
            w = r ? rd_window : wr_window;
            if (on_t < 0 && w === 1'b1) on_t = m.ticks - t0;
            if (on_t == m.ticks - t0 - 1) code_in = term_code;
            if (on_t >= 0 && w === 1'b0) off_t = m.ticks - t0;
        end
        repeat (4) @(posedge pclk);
    endtask : span
    task automatic wsel(input logic [1:0] s);
        np = 0;
        while (2'(term_sel) !== s && np < 200) begin
            @(posedge pclk);
            np++;
        end
        dt = m.ticks - t0;
    endtask : wsel
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, i == 1 ? odtc_pkg::LAT_RESET : 32'h0);
            chk({31'h0, err}, {31'h0, i == 4});
        end
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        cmd(3'h4, 1'b0, odtc_pkg::MRS_SEL_MR1, 14'h0200);
        cmd(3'h4, 1'b0, odtc_pkg::MRS_SEL_MR5, 14'h00C0);
        cmd(3'h4, 1'b0, odtc_pkg::MRS_SEL_MR2, 14'h0800);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000_0342);
        cmd(3'h1, 1'b0, 3'h0, 14'h0);
        span(1'b0);
        chk(on_t, -1);
        chk(32'(term_sel), 32'h1);
        cmd(3'h4, 1'b0, odtc_pkg::MRS_SEL_MR2, 14'h0A00);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 8'h00, {27'h0, wc[i]});
            cmd(3'h1, i == 2, 3'h0, 14'h0);
            span(1'b0);
            chk(on_t, won[i]);
            chk(off_t, woff[i]);
            chk({29'h0, code_in}, 32'h5);
            chk(32'(term_sel), 32'h1);
        end
        apb(1'b1, 8'h00, 32'h0);
        m.pin(1'b1);
        t0 = m.ticks + 1;
        wsel(2'h2);
        chk(dt, 9);
        chk({29'h0, term_code}, 32'h2);
        cmd(3'h1, 1'b0, 3'h0, 14'h0);
        span(1'b0);
        chk({29'h0, code_in}, 32'h5);
        chk(32'(term_sel), 32'h2);
        m.pin(1'b0);
        t0 = m.ticks + 1;
        wsel(2'h1);
        chk(dt, 9);
        cmd(3'h2, 1'b0, 3'h0, 14'h0);
        span(1'b1);
        chk(on_t, 12);
        chk(off_t, 18);
        chk({29'h0, code_in}, 32'h0);
        apb(1'b1, 8'h00, 32'h0000_000E);
        cmd(3'h2, 1'b0, 3'h0, 14'h0);
        span(1'b1);
        chk(on_t, 11);
        chk(off_t, 17);
        apb(1'b1, 8'h04, 32'h000A_0B0E);
        apb(1'b1, 8'h00, 32'h1);
        m.pin(1'b1);
        wsel(2'h2);
        chk({31'h0, np < 10}, 32'h1);
        cmd(3'h1, 1'b0, 3'h0, 14'h0);
        span(1'b0);
        chk(on_t, -1);
        apb(1'b1, 8'h00, 32'h0);
        cmd(3'h4, 1'b0, odtc_pkg::MRS_SEL_MR2, 14'h0000);
        cmd(3'h1, 1'b0, 3'h0, 14'h0);
        span(1'b0);
        chk(on_t, -1);
        test_done();
    end
    initial begin
        #400000;
        n_errors++;
        test_done();
    end
endmodule : tb_top

/* verilog/odtc_ctrl.sv */
// on-die termination controller with register slave on the peripheral bus
`timescale 1ns/1ps
// Functional notes
// - no termination while driving read data; re-enable after the postamble
// - write termination switching enabled when either select bit A9 or A10 is set
// - nominal strength comes from first mode register bits 10..8
// - write strength comes from second mode register bits 11..9
// - park strength comes from fifth mode register bits 8..6
// - without writes, pin switches nominal after direct latency; park while pin low
// - a write with switching enabled and the loop on selects write strength after its on latency, unless a read window is open
// - write strength drops after the short or long latency chosen per burst
// - write on latency is write latency minus 2, or minus 3 with long preamble
// - short preamble, no check code: off at on latency plus 4 or 6
// - off offsets 7/7 short with check code, 5/7 long, 8/8 long with code
// - no write termination switching while the delay-locked loop is off
// - asynchronous termination control whenever the delay-locked loop is off
// - asynchronous mode applies the pin request without added or parity latency
// - asynchronous turn-on follows the synchronised pin at the next bus clock, not a memory clock edge
// - read disables termination from read latency minus 2 or 3 for half burst plus 2-4
// - synchronous direct latency is write plus added plus parity latency minus 2 or 3
module odtc_ctrl (
    // bus clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // peripheral bus slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory-side pins
    input wire logic ck,
    input wire logic odt,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic cmd_mrs,
    input wire logic otf_bc4,
    input wire logic [2:0] mrs_sel,
    input wire logic [13:0] mrs_addr,
    // termination state
    output odtc_pkg::odtc_term_t term_sel,
    output logic [2:0] term_code,
    output logic wr_window,
    output logic rd_window
);
    logic [31:0] ctrl;
    logic [31:0] lat;
    logic [13:0] mr1;
    logic [13:0] mr2;
    logic [13:0] mr5;
    logic [odtc_pkg::SYNC_W-1:0] pin_s;
    logic ck_s;
    logic odt_s;
    logic wr_s;
    logic rd_s;
    logic mrs_s;
    logic otf_s;
    logic [2:0] sel_s;
    logic [13:0] addr_s;
    logic ck_q;
    logic tick;
    logic dll_off;
    logic pre2t;
    logic crc_en;
    logic [1:0] bl_mode;
    logic bc4_now;
    logic wr_en;
    logic [2:0] nom_code;
    logic [2:0] wr_code;
    logic [2:0] park_code;
    int wl;
    int rl;
    int sub;
    int cnw;
    int rodtl;
    int rd_hold;
    logic [odtc_pkg::HIST_IW-1:0] idx_cnw;
    logic [odtc_pkg::HIST_IW-1:0] idx_cwn4;
    logic [odtc_pkg::HIST_IW-1:0] idx_cwn8;
    logic [odtc_pkg::HIST_IW-1:0] idx_rdon;
    logic [odtc_pkg::HIST_IW-1:0] idx_rd4;
    logic [odtc_pkg::HIST_IW-1:0] idx_rd8;
    logic [1:0] wr_on_tap;
    logic [1:0] wr_s4_tap;
    logic [1:0] wr_l8_tap;
    logic [1:0] rd_on_tap;
    logic [1:0] rd_s4_tap;
    logic [1:0] rd_l8_tap;
    logic [0:0] odt_tap;
    logic wr_on;
    logic wr_off;
    logic rd_on;
    logic rd_off;
    logic nom_req;
    logic set_wr;
    logic set_rd;
    odtc_pkg::odtc_term_t next_sel;
    logic [2:0] next_code;
    logic bus_access;
    logic addr_hit;

    // latency in ticks to a tap index, clamped to the history
    function automatic logic [odtc_pkg::HIST_IW-1:0] odtc_tap(input int n);
        if (n < 1) begin
            return '0;
        end
        if (n > odtc_pkg::HIST_DEPTH) begin
            return odtc_pkg::HIST_IW'(odtc_pkg::HIST_DEPTH - 1);
        end
        return odtc_pkg::HIST_IW'(n - 1);
    endfunction : odtc_tap

    // offset of write-off latency beyond the write-on latency
    function automatic int odtc_cwn(input logic p2, input logic crc, input logic bc4);
        if (!p2 && !crc) begin
            return bc4 ? odtc_pkg::CWN4_1T : odtc_pkg::CWN8_1T;
        end
        if (!p2) begin
            return odtc_pkg::CWN_1T_CRC;
        end
        if (!crc) begin
            return bc4 ? odtc_pkg::CWN4_2T : odtc_pkg::CWN8_2T;
        end
        return odtc_pkg::CWN_2T_CRC;
    endfunction : odtc_cwn

    // pin synchroniser and memory clock edge finder
    odtc_sync #(
        .W(odtc_pkg::SYNC_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({ck, odt, cmd_wr, cmd_rd, cmd_mrs, otf_bc4, mrs_sel, mrs_addr}),
        .dout(pin_s)
    );
    assign {ck_s, odt_s, wr_s, rd_s, mrs_s, otf_s, sel_s, addr_s} = pin_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_q <= 1'b0;
        end else begin
            ck_q <= ck_s;
        end
    end
    assign tick = ck_s && !ck_q;

    // configuration decode
    assign dll_off = ctrl[odtc_pkg::CTRL_DLL_OFF];
    assign pre2t = ctrl[odtc_pkg::CTRL_PRE2T];
    assign crc_en = ctrl[odtc_pkg::CTRL_CRC];
    assign bl_mode = ctrl[odtc_pkg::CTRL_BL_LSB +: 2];
    assign bc4_now = (bl_mode == odtc_pkg::BL_FIXED4) || ((bl_mode == odtc_pkg::BL_OTF) && otf_s);
    assign wr_en = mr2[odtc_pkg::MR2_DYN_A9] || mr2[odtc_pkg::MR2_DYN_A10];
    assign nom_code = mr1[odtc_pkg::MR1_NOM_LSB +: 3];
    assign wr_code = mr2[odtc_pkg::MR2_WR_LSB +: 3];
    assign park_code = mr5[odtc_pkg::MR5_PARK_LSB +: 3];

    // latency arithmetic in memory clock ticks
    always_comb begin
        wl = int'(lat[odtc_pkg::LAT_CWL_LSB +: 6]) + int'(lat[odtc_pkg::LAT_AL_LSB +: 6])
            + int'(lat[odtc_pkg::LAT_PL_LSB +: 4]);
        rl = int'(lat[odtc_pkg::LAT_CL_LSB +: 6]) + int'(lat[odtc_pkg::LAT_AL_LSB +: 6])
            + int'(lat[odtc_pkg::LAT_PL_LSB +: 4]);
        sub = pre2t ? odtc_pkg::PRE2_SUB : odtc_pkg::PRE1_SUB;
        cnw = wl - sub;
        rodtl = rl - sub;
        rd_hold = (pre2t ? odtc_pkg::RD_HOLD_2T : odtc_pkg::RD_HOLD_1T)
            + (crc_en ? odtc_pkg::RD_CRC_EXTRA : 0);
    end
    assign idx_cnw = odtc_tap(cnw);
    assign idx_cwn4 = odtc_tap(cnw + odtc_cwn(pre2t, crc_en, 1'b1));
    assign idx_cwn8 = odtc_tap(cnw + odtc_cwn(pre2t, crc_en, 1'b0));
    assign idx_rdon = odtc_tap(rodtl);
    assign idx_rd4 = odtc_tap(rodtl + odtc_pkg::BC4_HALF + rd_hold);
    assign idx_rd8 = odtc_tap(rodtl + odtc_pkg::BL8_HALF + rd_hold);

    // write, read and pin histories
    odtc_delay_line #(
        .W(2)
    ) u_wr_hist (
        .pclk(pclk),
        .presetn(presetn),
        .shift_en(tick),
        .din({bc4_now, wr_s}),
        .idx_a(idx_cnw),
        .idx_b(idx_cwn4),
        .idx_c(idx_cwn8),
        .tap_a(wr_on_tap),
        .tap_b(wr_s4_tap),
        .tap_c(wr_l8_tap)
    );

    odtc_delay_line #(
        .W(2)
    ) u_rd_hist (
        .pclk(pclk),
        .presetn(presetn),
        .shift_en(tick),
        .din({bc4_now, rd_s}),
        .idx_a(idx_rdon),
        .idx_b(idx_rd4),
        .idx_c(idx_rd8),
        .tap_a(rd_on_tap),
        .tap_b(rd_s4_tap),
        .tap_c(rd_l8_tap)
    );

    odtc_delay_line #(
        .W(1)
    ) u_odt_hist (
        .pclk(pclk),
        .presetn(presetn),
        .shift_en(tick),
        .din(odt_s),
        .idx_a(idx_cnw),
        .idx_b(idx_cnw),
        .idx_c(idx_cnw),
        .tap_a(odt_tap),
        .tap_b(),
        .tap_c()
    );

    assign wr_on = wr_on_tap[0];
    assign wr_off = (wr_s4_tap[0] && wr_s4_tap[1]) || (wr_l8_tap[0] && !wr_l8_tap[1]);
    assign rd_on = rd_on_tap[0];
    assign rd_off = (rd_s4_tap[0] && rd_s4_tap[1]) || (rd_l8_tap[0] && !rd_l8_tap[1]);

    // mode register capture from set commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mr1 <= odtc_pkg::MR_RESET;
            mr2 <= odtc_pkg::MR_RESET;
            mr5 <= odtc_pkg::MR_RESET;
        end else if (tick && mrs_s) begin
            if (sel_s == odtc_pkg::MRS_SEL_MR1) begin
                mr1 <= addr_s;
            end
            if (sel_s == odtc_pkg::MRS_SEL_MR2) begin
                mr2 <= addr_s;
            end
            if (sel_s == odtc_pkg::MRS_SEL_MR5) begin
                mr5 <= addr_s;
            end
        end
    end

    // nominal request: delayed pin in synchronous mode, direct pin otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nom_req <= 1'b0;
        end else if (dll_off) begin
            nom_req <= odt_s;
        end else if (tick) begin
            nom_req <= odt_tap[0];
        end
    end

    // write window, set wins over clear
    assign set_wr = tick && wr_on && wr_en && !dll_off;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_window <= 1'b0;
        end else if (set_wr) begin
            wr_window <= 1'b1;
        end else if ((tick && wr_off) || dll_off || !wr_en) begin
            wr_window <= 1'b0;
        end
    end

    // read disable window, set wins over clear
    assign set_rd = tick && rd_on;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_window <= 1'b0;
        end else if (set_rd) begin
            rd_window <= 1'b1;
        end else if (tick && rd_off) begin
            rd_window <= 1'b0;
        end
    end

    // termination selection by priority
    always_comb begin
        next_sel = odtc_pkg::TERM_OFF;
        next_code = 3'h0;
        if (rd_window) begin
            next_sel = odtc_pkg::TERM_OFF;
        end else if (wr_window) begin
            next_sel = odtc_pkg::TERM_WR;
            next_code = wr_code;
        end else if (nom_req && (nom_code != 3'h0)) begin
            next_sel = odtc_pkg::TERM_NOM;
            next_code = nom_code;
        end else if (park_code != 3'h0) begin
            next_sel = odtc_pkg::TERM_PARK;
            next_code = park_code;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_sel <= odtc_pkg::TERM_OFF;
            term_code <= 3'h0;
        end else begin
            term_sel <= next_sel;
            term_code <= next_code;
        end
    end

    // bus slave, zero wait states
    assign bus_access = psel && penable;
    assign addr_hit = (paddr[7:0] == odtc_pkg::ADDR_CTRL) || (paddr[7:0] == odtc_pkg::ADDR_LAT)
        || (paddr[7:0] == odtc_pkg::ADDR_MODE) || (paddr[7:0] == odtc_pkg::ADDR_STAT);
    assign pready = 1'b1;
    assign pslverr = bus_access && (!addr_hit || (paddr[31:8] != 24'h000000));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= odtc_pkg::CTRL_RESET;
            lat <= odtc_pkg::LAT_RESET;
        end else if (bus_access && pwrite && !pslverr) begin
            if (paddr[7:0] == odtc_pkg::ADDR_CTRL) begin
                ctrl <= {27'h0, pwdata[4:0]};
            end
            if (paddr[7:0] == odtc_pkg::ADDR_LAT) begin
                lat <= {4'h0, pwdata[27:24], 2'h0, pwdata[21:16], 2'h0, pwdata[13:8],
                    2'h0, pwdata[5:0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            case (paddr[7:0])
                odtc_pkg::ADDR_CTRL: prdata <= ctrl;
                odtc_pkg::ADDR_LAT: prdata <= lat;
                odtc_pkg::ADDR_MODE: begin
                    prdata[odtc_pkg::MODE_NOM_LSB +: 3] <= nom_code;
                    prdata[odtc_pkg::MODE_WR_LSB +: 3] <= wr_code;
                    prdata[odtc_pkg::MODE_PARK_LSB +: 3] <= park_code;
                end
                odtc_pkg::ADDR_STAT: begin
                    prdata[odtc_pkg::STAT_SEL_LSB +: 2] <= term_sel;
                    prdata[odtc_pkg::STAT_CODE_LSB +: 3] <= term_code;
                    prdata[odtc_pkg::STAT_WR_WIN] <= wr_window;
                    prdata[odtc_pkg::STAT_RD_WIN] <= rd_window;
                end
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    chk_read_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        rd_window |=> term_sel == odtc_pkg::TERM_OFF)
        else $error("termination applied during read drive");
    chk_wr_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (term_sel == odtc_pkg::TERM_WR) |-> $past(mr2[10] || mr2[9], 2))
        else $error("write termination without enable bits");
    chk_nom_code: assert property (@(posedge pclk) disable iff (!presetn)
        (term_sel == odtc_pkg::TERM_NOM) |-> term_code == $past(mr1[10:8]))
        else $error("nominal strength mismatch");
    chk_wr_code: assert property (@(posedge pclk) disable iff (!presetn)
        (term_sel == odtc_pkg::TERM_WR) |-> term_code == $past(mr2[11:9]))
        else $error("write strength mismatch");
    chk_park_code: assert property (@(posedge pclk) disable iff (!presetn)
        (term_sel == odtc_pkg::TERM_PARK) |-> term_code == $past(mr5[8:6]))
        else $error("park strength mismatch");
    chk_park_low: assert property (@(posedge pclk) disable iff (!presetn)
        (!rd_window && !wr_window && !nom_req && mr5[8:6] != 3'h0)
        |=> term_sel == odtc_pkg::TERM_PARK)
        else $error("park not applied while pin low");
    chk_wr_start: assert property (@(posedge pclk) disable iff (!presetn)
        (set_wr && !rd_window) |=> wr_window ##1 (term_sel == odtc_pkg::TERM_WR || rd_window))
        else $error("write termination not selected after on latency");
    chk_dll_off_wr: assert property (@(posedge pclk) disable iff (!presetn)
        dll_off |=> !wr_window)
        else $error("write window while loop off");
    chk_async_nom: assert property (@(posedge pclk) disable iff (!presetn)
        (dll_off && odt_s) |=> nom_req)
        else $error("asynchronous pin request delayed");
    chk_wr_end: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_window && tick && wr_off && !set_wr) |=> !wr_window)
        else $error("write window not closed at off latency");
    cov_write_win: cover property (@(posedge pclk) disable iff (!presetn)
        term_sel == odtc_pkg::TERM_WR);
    cov_read_win: cover property (@(posedge pclk) disable iff (!presetn) rd_window);
    cov_async_nom: cover property (@(posedge pclk) disable iff (!presetn)
        dll_off && term_sel == odtc_pkg::TERM_NOM);
endmodule : odtc_ctrl

/* verilog/odtc_delay_line.sv */
// tick-stepped history of command events with three variable taps
`timescale 1ns/1ps
module odtc_delay_line #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // one shift per memory clock tick
    input wire logic shift_en,
    input wire logic [W-1:0] din,
    // taps, index 0 is the sample of the previous tick
    input wire logic [odtc_pkg::HIST_IW-1:0] idx_a,
    input wire logic [odtc_pkg::HIST_IW-1:0] idx_b,
    input wire logic [odtc_pkg::HIST_IW-1:0] idx_c,
    output logic [W-1:0] tap_a,
    output logic [W-1:0] tap_b,
    output logic [W-1:0] tap_c
);
    logic [W-1:0] hist [odtc_pkg::HIST_DEPTH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < odtc_pkg::HIST_DEPTH; i++) begin
                hist[i] <= '0;
            end
        end else if (shift_en) begin
            hist[0] <= din;
            for (int i = 1; i < odtc_pkg::HIST_DEPTH; i++) begin
                hist[i] <= hist[i-1];
            end
        end
    end

    assign tap_a = hist[idx_a];
    assign tap_b = hist[idx_b];
    assign tap_c = hist[idx_c];
endmodule : odtc_delay_line

/* verilog/odtc_pkg.sv */
// constants, register map and types of the on-die termination controller
package odtc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LAT = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    // control register fields
    localparam int CTRL_DLL_OFF = 0;
    localparam int CTRL_PRE2T = 1;
    localparam int CTRL_CRC = 2;
    localparam int CTRL_BL_LSB = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // latency register fields, 6 bits each except parity latency
    localparam int LAT_CL_LSB = 0;
    localparam int LAT_CWL_LSB = 8;
    localparam int LAT_AL_LSB = 16;
    localparam int LAT_PL_LSB = 24;
    localparam logic [31:0] LAT_RESET = 32'h0000_0B0E;
    // mode register status fields
    localparam int MODE_NOM_LSB = 0;
    localparam int MODE_WR_LSB = 4;
    localparam int MODE_PARK_LSB = 8;
    // status register fields
    localparam int STAT_SEL_LSB = 0;
    localparam int STAT_CODE_LSB = 2;
    localparam int STAT_WR_WIN = 5;
    localparam int STAT_RD_WIN = 6;
    // mode register fields seen in mode register set commands
    localparam int MR1_NOM_LSB = 8;
    localparam int MR2_WR_LSB = 9;
    localparam int MR2_DYN_A9 = 9;
    localparam int MR2_DYN_A10 = 10;
    localparam int MR5_PARK_LSB = 6;
    localparam logic [2:0] MRS_SEL_MR1 = 3'h1;
    localparam logic [2:0] MRS_SEL_MR2 = 3'h2;
    localparam logic [2:0] MRS_SEL_MR5 = 3'h5;
    localparam logic [13:0] MR_RESET = 14'h0000;
    // burst length modes
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_FIXED4 = 2'h1;
    localparam logic [1:0] BL_OTF = 2'h2;
    // latency offsets in clock ticks
    localparam int PRE1_SUB = 2;
    localparam int PRE2_SUB = 3;
    localparam int CWN4_1T = 4;
    localparam int CWN8_1T = 6;
    localparam int CWN_1T_CRC = 7;
    localparam int CWN4_2T = 5;
    localparam int CWN8_2T = 7;
    localparam int CWN_2T_CRC = 8;
    localparam int RD_HOLD_1T = 2;
    localparam int RD_HOLD_2T = 3;
    localparam int RD_CRC_EXTRA = 1;
    localparam int BL8_HALF = 4;
    localparam int BC4_HALF = 2;
    // history depth in clock ticks
    localparam int HIST_DEPTH = 64;
    localparam int HIST_IW = 6;
    localparam int SYNC_W = 23;
    typedef enum logic [1:0] {TERM_OFF, TERM_PARK, TERM_NOM, TERM_WR} odtc_term_t;
endpackage : odtc_pkg

/* verilog/odtc_sync.sv */
// three-stage input synchroniser, value taken once stages two and three agree
`timescale 1ns/1ps
module odtc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous input and its settled copy
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // each bit settles on its own once stages two and three match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule : odtc_sync
